/* File: design/wdid_core.sv */
// word decrement and interrupt disable execution unit with AHB-Lite register slave
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - decrement the even register and its successor together as one 16-bit word
// - opcode 8F clears bit 0 of system_mode_reg, other bits kept
// - requests keep setting pending bits while interrupts are disabled
// - service drops one cycle after the global enable bit clears and stays off while it is clear
// - interrupt_disable_op leaves every condition flag unchanged
module wdid_core
(
  input  wire logic                         clock,
  input  wire logic                         reset,
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic      [31:0]                  hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  input  wire logic [wdid_pkg::NUM_IRQ-1:0] irq_req,
  output logic                              irq_service,
  output logic      [2:0]                   irq_level
);
  import wdid_pkg::*;

  typedef struct packed {
    logic [REG_COUNT-1:0][7:0] regs;
    logic [7:0]                flags;
    logic [7:0]                sysmode;
    logic [7:0]                int_mask;
    logic                      dphase;
    logic                      wr;
    logic [7:0]                addr;
    logic [31:0]               rdata;
    logic                      ready;
    logic                      resp;
    wdid_exec_type             state;
    logic [3:0]                ptr;
    logic                      illegal;
  } wdid_core_state_type;

  wdid_core_state_type s_q;
  wdid_core_state_type s_d;

  logic [NUM_IRQ-1:0] pend;
  logic [NUM_IRQ-1:0] pend_clear;
  logic               service;
  logic [15:0]        pair_cur;
  logic [15:0]        pair_dec;
  logic               bus_wr;
  logic [7:0]         cmd_opc;
  logic [7:0]         cmd_opd;

  // operand word: high byte at the even address, low byte at the next one
  assign pair_cur = {s_q.regs[s_q.ptr], s_q.regs[{s_q.ptr[3:1], 1'b1}]};
  assign pair_dec = pair_cur - 16'h0001;
  assign bus_wr   = s_q.dphase && s_q.wr;
  assign cmd_opc  = hwdata[CMD_OPC_LSB +: 8];
  assign cmd_opd  = hwdata[CMD_OPD_LSB +: 8];

  // write-one-to-clear of pending bits; the gate lets a new request win
  assign pend_clear = (bus_wr && s_q.addr == OFS_INT_PEND) ? hwdata[7:0] : 8'h00;

  // next-state logic: bus slave, command decode, execution
  always_comb
  begin
    s_d        = s_q;
    // address phase: one wait state so read data comes from a flop
    s_d.dphase = hsel && htrans[1] && hready;
    s_d.ready  = !s_d.dphase;
    if (s_d.dphase)
    begin
      s_d.wr   = hwrite;
      s_d.addr = haddr[7:0];
    end
    // data phase
    if (s_q.dphase && !s_q.wr)
    begin
      if (s_q.addr[7:6] == REGF_WINDOW)
        s_d.rdata = {24'h000000, s_q.regs[s_q.addr[5:2]]};
      else
      begin
        case (s_q.addr)
          OFS_STATUS:
          begin
            // busy is never seen by a read: a transfer outlasts the one-cycle execution
            s_d.rdata              = 32'h00000000;
            s_d.rdata[STS_BUSY]    = s_q.state == EXEC_RUN;
            s_d.rdata[STS_ILLEGAL] = s_q.illegal;
            s_d.rdata[STS_SERVICE] = service;
          end
          OFS_FLAGS:    s_d.rdata = {24'h000000, s_q.flags};
          OFS_SYSMODE:  s_d.rdata = {24'h000000, s_q.sysmode};
          OFS_INT_MASK: s_d.rdata = {24'h000000, s_q.int_mask};
          OFS_INT_PEND: s_d.rdata = {24'h000000, pend};
          default:      s_d.rdata = 32'h00000000;  // unmapped and command read as zero
        endcase
      end
    end
    if (bus_wr)
    begin
      if (s_q.addr[7:6] == REGF_WINDOW)
        s_d.regs[s_q.addr[5:2]] = hwdata[7:0];
      else
      begin
        case (s_q.addr)
          OFS_STATUS:   if (hwdata[STS_ILLEGAL]) s_d.illegal = 1'b0;
          OFS_FLAGS:    s_d.flags    = hwdata[7:0];
          OFS_SYSMODE:  s_d.sysmode  = hwdata[7:0];
          OFS_INT_MASK: s_d.int_mask = hwdata[7:0];
          OFS_CMD:
          begin
            // a command while busy is dropped; only the register file address bits are used
            if (s_q.state == EXEC_IDLE)
            begin
              unique case (cmd_opc)
                OPC_WDEC_REG:
                begin
                  s_d.ptr   = {cmd_opd[3:1], 1'b0};
                  s_d.state = EXEC_RUN;
                end
                OPC_WDEC_IND:
                begin
                  s_d.ptr   = {s_q.regs[cmd_opd[3:0]][3:1], 1'b0};
                  s_d.state = EXEC_RUN;
                end
                OPC_INT_DISABLE:
                  s_d.sysmode[SYSMODE_GIE] = 1'b0;
                default:
                  s_d.illegal = 1'b1;
              endcase
            end
          end
          default: ;
        endcase
      end
    end
    // execution wins over a bus write landing in the same cycle
    if (s_q.state == EXEC_RUN)
    begin
      s_d.regs[s_q.ptr]                 = pair_dec[15:8];
      s_d.regs[{s_q.ptr[3:1], 1'b1}]    = pair_dec[7:0];
      s_d.flags[FLG_Z]                  = pair_dec == 16'h0000;
      s_d.flags[FLG_S]                  = pair_dec[15];
      s_d.flags[FLG_V]                  = pair_cur == 16'h8000;
      s_d.state                         = EXEC_IDLE;
    end
  end

  // state register, synchronous reset to constants
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      s_q          <= '0;
      s_q.ready    <= 1'b1;
      s_q.flags    <= RST_FLAGS;
      s_q.sysmode  <= RST_SYSMODE;
      s_q.int_mask <= RST_INT_MASK;
      s_q.state    <= EXEC_IDLE;
    end
    else
      s_q <= s_d;
  end

  // pending latches and service gating
  wdid_int_gate u_gate
  (
    .clock         (clock),
    .reset         (reset),
    .irq_req       (irq_req),
    .global_enable (s_q.sysmode[SYSMODE_GIE]),
    .int_mask      (s_q.int_mask),
    .pend_clear    (pend_clear),
    .pend          (pend),
    .service       (service),
    .level         (irq_level)
  );

  assign hrdata      = s_q.rdata;
  assign hreadyout   = s_q.ready;
  assign hresp       = s_q.resp;
  assign irq_service = service;

  // checking helpers
  logic       exec_fire;
  logic       cmd_fire;
  logic       disable_fire;
  logic [2:0] flags_keep;
  assign exec_fire    = s_q.state == EXEC_RUN;
  assign cmd_fire     = bus_wr && s_q.addr == OFS_CMD && s_q.state == EXEC_IDLE;
  assign disable_fire = cmd_fire && cmd_opc == OPC_INT_DISABLE;
  // each kept flag watched on its own, so two flips cannot cancel out
  assign flags_keep   = {s_q.flags[FLG_C], s_q.flags[FLG_D], s_q.flags[FLG_H]};

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_dec_result: assert property (exec_fire |=> pair_cur == $past(pair_dec))
    else $error("word decrement wrong");
  chk_dec_even: assert property (exec_fire |-> !s_q.ptr[0])
    else $error("pair pointer odd");
  chk_dec_wrap: assert property (exec_fire && pair_cur == 16'h0 |=> pair_cur == 16'hFFFF)
    else $error("borrow not carried");
  chk_dec_zero: assert property (exec_fire |=> s_q.flags[FLG_Z] == (pair_cur == 16'h0))
    else $error("zero flag wrong");
  chk_dec_sign: assert property (exec_fire |=> s_q.flags[FLG_S] == pair_cur[15])
    else $error("sign flag wrong");
  chk_dec_ovf: assert property
    (exec_fire |=> s_q.flags[FLG_V] == ($past(pair_cur) == 16'h8000))
    else $error("overflow flag wrong");
  chk_dec_keep: assert property (exec_fire |=> $stable(flags_keep))
    else $error("carry group changed");
  chk_disable_gie: assert property
    (disable_fire |=> !s_q.sysmode[SYSMODE_GIE] && s_q.sysmode[7:1] == $past(s_q.sysmode[7:1]))
    else $error("enable not cleared");
  chk_disable_flags: assert property (disable_fire |=> $stable(s_q.flags))
    else $error("flags changed");
  chk_disable_svc: assert property (disable_fire |-> ##2 !irq_service [*3])
    else $error("serviced after disable");
  chk_ready_pulse: assert property (!hreadyout |=> hreadyout)
    else $error("wait state too long");
  chk_illegal_set: assert property
    (cmd_fire && cmd_opc != OPC_WDEC_REG && cmd_opc != OPC_WDEC_IND &&
     cmd_opc != OPC_INT_DISABLE |=> s_q.illegal)
    else $error("illegal opcode not flagged");

  // main scenarios the bench is expected to reach
  cov_dec_reg: cover property (cmd_fire && cmd_opc == OPC_WDEC_REG ##1 exec_fire);
  cov_dec_ind: cover property (cmd_fire && cmd_opc == OPC_WDEC_IND ##1 exec_fire);
  cov_disable: cover property (disable_fire && s_q.sysmode[SYSMODE_GIE]);

endmodule // wdid_core

/* File: design/wdid_int_gate.sv */
// pending latches and global-enable gating of interrupt service
`timescale 1ns/1ps
module wdid_int_gate
(
  input  wire logic                         clock,
  input  wire logic                         reset,
  input  wire logic [wdid_pkg::NUM_IRQ-1:0] irq_req,
  input  wire logic                         global_enable,
  input  wire logic [wdid_pkg::NUM_IRQ-1:0] int_mask,
  input  wire logic [wdid_pkg::NUM_IRQ-1:0] pend_clear,
  output logic      [wdid_pkg::NUM_IRQ-1:0] pend,
  output logic                              service,
  output logic      [2:0]                   level
);
  import wdid_pkg::*;

  typedef struct packed {
    logic [NUM_IRQ-1:0] pend;
    logic               service;
    logic [2:0]         level;
  } wdid_gate_state_type;

  wdid_gate_state_type s_q;
  wdid_gate_state_type s_d;

  // lowest set index wins; fixed priority keeps the vector choice cheap
  function automatic logic [2:0] first_set(input logic [NUM_IRQ-1:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NUM_IRQ - 1; i >= 0; i--)
    begin
      if (v[i])
        idx = 3'(i);
    end
    return idx;
  endfunction

  // pending bits latch regardless of the global enable; a new request beats a clear
  always_comb
  begin
    s_d         = s_q;
    s_d.pend    = (s_q.pend & ~pend_clear) | irq_req;
    s_d.service = global_enable && |(s_q.pend & int_mask);
    s_d.level   = first_set(s_q.pend & int_mask);
  end

  // state register
  always_ff @(posedge clock)
  begin
    if (reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign pend    = s_q.pend;
  assign service = s_q.service;
  assign level   = s_q.level;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_pend_latch: assert property
    ((irq_req != 8'h00) |=> ((pend & $past(irq_req)) == $past(irq_req)))
    else $error("request lost");
  chk_no_service: assert property (!global_enable |=> !service)
    else $error("service while disabled");
  chk_service_up: assert property
    ((global_enable && (pend & int_mask) != 8'h00) |=> service)
    else $error("service missing");

  cov_service: cover property (global_enable && (pend & int_mask) != 8'h00 ##1 service);
  cov_held_off: cover property (!global_enable && pend != 8'h00 ##1 !service);

endmodule // wdid_int_gate

/* File: design/wdid_pkg.sv */
// shared constants and types for the word decrement / interrupt disable block
package wdid_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_FLAGS    = 8'h08;
  localparam logic [7:0] OFS_SYSMODE  = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  localparam logic [7:0] OFS_INT_PEND = 8'h14;
  localparam logic [1:0] REGF_WINDOW  = 2'h1;   // haddr[7:6] of working register file

  // opcodes accepted on the command register
  localparam logic [7:0] OPC_WDEC_REG    = 8'h80;
  localparam logic [7:0] OPC_WDEC_IND    = 8'h81;
  localparam logic [7:0] OPC_INT_DISABLE = 8'h8F;

  // command register fields
  localparam int unsigned CMD_OPC_LSB = 0;
  localparam int unsigned CMD_OPD_LSB = 8;

  // condition flag positions
  localparam int unsigned FLG_C = 7;
  localparam int unsigned FLG_Z = 6;
  localparam int unsigned FLG_S = 5;
  localparam int unsigned FLG_V = 4;
  localparam int unsigned FLG_D = 3;
  localparam int unsigned FLG_H = 2;

  // status register bits
  localparam int unsigned STS_BUSY    = 0;
  localparam int unsigned STS_ILLEGAL = 1;
  localparam int unsigned STS_SERVICE = 2;

  // global enable bit of system_mode_reg
  localparam int unsigned SYSMODE_GIE = 0;

  // sizes
  localparam int unsigned REG_COUNT = 16;
  localparam int unsigned NUM_IRQ   = 8;

  // reset values
  localparam logic [7:0] RST_FLAGS    = 8'h00;
  localparam logic [7:0] RST_SYSMODE  = 8'h00;
  localparam logic [7:0] RST_INT_MASK = 8'h00;

  // execution sequencer
  typedef enum logic {EXEC_IDLE, EXEC_RUN} wdid_exec_type;

endpackage

/* File: verif/tb_word_decrement_and_int_disable.sv */
// self-checking bench for the word decrement / interrupt disable block
`timescale 1ns/1ps
module tb_word_decrement_and_int_disable;
  import wdid_pkg::*;

  logic                clock = 1'b0;
  logic                reset = 1'b1;
  logic                hsel = 1'b0;
  logic [31:0]         haddr = 32'h0;
  logic [1:0]          htrans = 2'h0;
  logic                hwrite = 1'b0;
  logic [2:0]          hsize = 3'h2;
  logic [31:0]         hwdata = 32'h0;
  logic                hready;
  logic [31:0]         hrdata;
  logic                hreadyout;
  logic                hresp;
  logic [NUM_IRQ-1:0]  irq_req = '0;
  logic                irq_service;
  logic [2:0]          irq_level;
  int                  fail_count = 0;
  int                  compares = 0;

  // one slave on the bus, so its ready is the bus ready
  assign hready = hreadyout;

  wdid_core dut (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq_req(irq_req), .irq_service(irq_service),
    .irq_level(irq_level));

  // free-running core clock, 8 ns period
  initial
  begin
    forever #4 clock = ~clock;
  end

  task automatic final_report;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  // look before the edge, so the coming edge is known to sample ready high
  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      $display("wrong value hreadyout expected 1 seen %b", hreadyout);
      fail_count++;
      final_report();
    end
  endtask

  // single word transfer; entered and left just after a rising edge
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= 2'b10;
    hwrite <= wr;
    wait_ready();
    @(posedge clock);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wdata;
    wait_ready();
    rdata = hrdata;
    @(posedge clock);
  endtask

  task automatic wr(input logic [31:0] addr, input logic [31:0] data);
    logic [31:0] d;
    xfer(1'b1, addr, data, d);
  endtask

  task automatic rd_check(input string name, input logic [31:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    xfer(1'b0, addr, 32'h0, d);
    check(name, exp, d);
    check("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic test_reset_values;
    rd_check("flags", 32'(OFS_FLAGS), {24'h0, RST_FLAGS});
    rd_check("sysmode", 32'(OFS_SYSMODE), {24'h0, RST_SYSMODE});
    rd_check("mask", 32'(OFS_INT_MASK), {24'h0, RST_INT_MASK});
    rd_check("pending", 32'(OFS_INT_PEND), 32'h0);
    rd_check("status", 32'(OFS_STATUS), 32'h0);
    // an unknown opcode only raises the sticky illegal bit, cleared by writing one
    wr(32'(OFS_CMD), 32'h00000055);
    rd_check("status illegal", 32'(OFS_STATUS), 32'h2);
    wr(32'(OFS_STATUS), 32'h2);
    rd_check("status cleared", 32'(OFS_STATUS), 32'h0);
    $display("test reset values done");
  endtask

  // load a pair, decrement it, judge both halves and the flags
  task automatic wdec(input logic [7:0] opc, input logic [7:0] opd, input int pair,
                      input logic [15:0] val);
    logic [15:0] res;
    logic [7:0]  flg;
    logic [31:0] hi;
    logic [31:0] lo;
    res = val - 16'h1;
    flg = 8'h8C;
    flg[FLG_Z] = (res == 16'h0);
    flg[FLG_S] = res[15];
    flg[FLG_V] = (val == 16'h8000);
    wr(32'h40 + 4 * pair, {24'h0, val[15:8]});
    wr(32'h40 + 4 * (pair + 1), {24'h0, val[7:0]});
    wr(32'(OFS_FLAGS), 32'h8C); // carry, decimal and half-carry preset
    wr(32'(OFS_CMD), {16'h0, opd, opc});
    xfer(1'b0, 32'h40 + 4 * pair, 32'h0, hi);
    check("pair high", {24'h0, res[15:8]}, hi);
    xfer(1'b0, 32'h40 + 4 * (pair + 1), 32'h0, lo);
    check("pair low", {24'h0, res[7:0]}, lo);
    // software zero test: OR of both result bytes instead of the zero flag
    check("or zero", {31'h0, res == 16'h0}, {31'h0, (hi | lo) == 32'h0});
    rd_check("flags", 32'(OFS_FLAGS), {24'h0, flg});
  endtask

  task automatic test_word_decrement;
    wdec(OPC_WDEC_REG, 8'h00, 0, 16'h1234);
    wdec(OPC_WDEC_REG, 8'h03, 2, 16'h0001);
    wdec(OPC_WDEC_REG, 8'h04, 4, 16'h8000);
    wdec(OPC_WDEC_REG, 8'h06, 6, 16'h0000);
    wdec(OPC_WDEC_REG, 8'h0E, 14, 16'h0100);
    // pointer register 8 names pair 10 after its low bit is dropped
    wr(32'h40 + 4 * 8, 32'h0B);
    wdec(OPC_WDEC_IND, 8'h08, 10, 16'h0F21);
    $display("test word decrement done");
  endtask

  task automatic test_int_disable;
    wr(32'(OFS_FLAGS), 32'hFF);
    wr(32'(OFS_INT_MASK), 32'hFF);
    wr(32'(OFS_SYSMODE), 32'hFF);
    irq_req <= 8'h08;
    @(posedge clock);
    irq_req <= 8'h00;
    @(posedge clock);
    @(negedge clock);
    check("service enabled", 32'h1, {31'h0, irq_service});
    check("level", 32'h3, {29'h0, irq_level});
    @(posedge clock);
    rd_check("status service", 32'(OFS_STATUS), 32'h4);
    wr(32'(OFS_CMD), {24'h0, OPC_INT_DISABLE});
    @(negedge clock);
    check("service disabled", 32'h0, {31'h0, irq_service});
    @(posedge clock);
    rd_check("sysmode", 32'(OFS_SYSMODE), 32'hFE);
    rd_check("flags", 32'(OFS_FLAGS), 32'hFF);
    // a request while disabled must still latch, but not be served
    irq_req <= 8'h20;
    @(posedge clock);
    irq_req <= 8'h00;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check("service held", 32'h0, {31'h0, irq_service});
    @(posedge clock);
    rd_check("pending", 32'(OFS_INT_PEND), 32'h28);
    // pending is cleared by writing one, here while still disabled; drop the older request
    wr(32'(OFS_INT_PEND), 32'h08);
    rd_check("pending cleared", 32'(OFS_INT_PEND), 32'h20);
    // re-enabling shows the request latched while disabled was kept
    wr(32'(OFS_SYSMODE), 32'h01);
    @(negedge clock);
    check("service again", 32'h1, {31'h0, irq_service});
    check("level again", 32'h5, {29'h0, irq_level});
    @(posedge clock);
    $display("test interrupt disable done");
  endtask

  // main sequence: reset for four cycles, then every scenario in turn
  initial
  begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    test_reset_values();
    test_word_decrement();
    test_int_disable();
    final_report();
  end

endmodule // tb_word_decrement_and_int_disable
